// file: design/srp_ctrl.sv
// What this block does
// - precharge all banks, wait precharge time, then refresh
// - only NOP during refresh cycle time
// - distributed refresh at period over row count
// - clock enable held low throughout self refresh
// - stay in self refresh at least row active time
// - clock stable before enable high, then NOPs
// - restart distributed refresh after self refresh exit
// - leave power-down before refresh period expires
// - exit power-down with NOP and enable high
// - raise output mask ahead of write after read
`timescale 1ns/100ps
`default_nettype none

module srp_ctrl
  import srp_pkg::*;
#(
  parameter int PD_LIMIT = PD_LIMIT_CYC
) (
  input  wire logic      mclk_i,
  input  wire logic      rst_i,
  input  wire logic      cmd_valid_i,
  input  wire srp_cmd_t  cmd_i,
  input  wire logic      dqm_i,
  input  wire logic      rd_wr_turn_i,
  input  wire logic      burst_active_i,
  input  wire logic      suspend_req_i,
  input  wire logic      self_ref_req_i,
  input  wire logic      power_down_req_i,
  output logic           cmd_ready_o,
  output srp_cmd_t       sd_cmd_o,
  output logic           sd_cke_o,
  output logic           sd_dqm_o,
  output logic           sd_clk_run_o,
  output srp_mode_t      mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  srp_state_t             state_reg;
  srp_state_t             state_next;
  srp_cmd_t               cmd_reg;
  srp_cmd_t               cmd_next;
  logic                   cke_reg;
  logic                   cke_next;
  logic                   clk_run_reg;
  logic                   clk_run_next;
  logic                   ready_reg;
  logic                   dqm_reg;
  logic [1:0]             mask_cnt_reg;
  logic [WAIT_W-1:0]      wait_reg;
  logic [WAIT_W-1:0]      wait_next;
  logic                   sr_go_reg;
  logic                   sr_go_next;
  logic [REFT_W-1:0]      ref_tmr_reg;
  logic [PEND_W-1:0]      pend_reg;
  logic [PD_W-1:0]        pd_cnt_reg;
  srp_mode_t              mode_reg;
  logic                   take;
  logic                   ref_tick;
  logic                   ref_done;
  logic                   sr_done;
  logic                   svc_want;
  logic                   suspend;
  logic                   pd_leave;

  // a burst must finish before refresh, self refresh or power-down is started; suspend only acts during a burst
  assign suspend  = suspend_req_i && burst_active_i;
  assign svc_want = (pend_reg != '0) || self_ref_req_i || power_down_req_i || suspend;
  assign take     = ready_reg && cmd_valid_i && (state_reg == ST_IDLE);
  assign ref_tick = (ref_tmr_reg == REFT_W'(REF_INT_CYC - 1));
  assign ref_done = (state_reg == ST_REF_WAIT) && (wait_reg == '0);
  assign sr_done  = (state_reg == ST_SR_EXIT) && (wait_reg == '0);
  assign pd_leave = !power_down_req_i || (pend_reg != '0) ||
                    (pd_cnt_reg == PD_W'(PD_LIMIT - 1));

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_next   = state_reg;
    cmd_next     = CMD_NOP;
    cke_next     = cke_reg;
    clk_run_next = clk_run_reg;
    wait_next    = (wait_reg != '0) ? wait_reg - WAIT_W'(1) : wait_reg;
    sr_go_next   = sr_go_reg;
    unique case (state_reg)
      ST_IDLE: begin
        cke_next = !suspend;
        if (take) begin
          cmd_next = cmd_i;
        end else if (!burst_active_i && (self_ref_req_i || pend_reg != '0)) begin
          cmd_next   = CMD_PRE_ALL;
          wait_next  = WAIT_W'(TRP_CYC - 1);
          sr_go_next = self_ref_req_i;
          state_next = ST_PRE_WAIT;
        end else if (!burst_active_i && power_down_req_i) begin
          cke_next   = 1'b0;
          state_next = ST_PD;
        end
      end
      ST_PRE_WAIT: begin
        if (wait_reg == '0) begin
          cmd_next = CMD_REFRESH;
          if (sr_go_reg) begin
            cke_next   = 1'b0;
            wait_next  = WAIT_W'(ROW_ACTIVE_TIME_CYC - 1);
            state_next = ST_SR_HOLD;
          end else begin
            wait_next  = WAIT_W'(REFRESH_CYCLE_TIME_CYC - 1);
            state_next = ST_REF_WAIT;
          end
        end
      end
      ST_REF_WAIT: begin
        if (wait_reg == '0) begin
          state_next = ST_IDLE;
        end
      end
      ST_SR_HOLD: begin
        cmd_next     = CMD_INHIBIT;
        cke_next     = 1'b0;
        clk_run_next = 1'b0;
        // stopping the clock saves power; the device runs on its own
        if (wait_reg == '0 && !self_ref_req_i) begin
          clk_run_next = 1'b1;
          wait_next    = WAIT_W'(CLKST_CYC - 1);
          state_next   = ST_SR_CLK;
        end
      end
      ST_SR_CLK: begin
        cke_next = 1'b0;
        if (wait_reg == '0) begin
          cke_next   = 1'b1;
          wait_next  = WAIT_W'(SELF_REFRESH_EXIT_TIME_CYC - 1);
          state_next = ST_SR_EXIT;
        end
      end
      ST_SR_EXIT: begin
        if (wait_reg == '0) begin
          sr_go_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_PD: begin
        if (pd_leave) begin
          cke_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      cmd_reg     <= CMD_INHIBIT;
      cke_reg     <= RST_CKE;
      clk_run_reg <= RST_CLK_RUN;
      wait_reg    <= '0;
      sr_go_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      cke_reg     <= cke_next;
      clk_run_reg <= clk_run_next;
      wait_reg    <= wait_next;
      sr_go_reg   <= sr_go_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user handshake: a pending service drops ready one cycle ahead

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == ST_IDLE) && !svc_want;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // distributed refresh timer and backlog

  always_ff @(posedge mclk_i) begin
    if (rst_i || sr_done) begin
      ref_tmr_reg <= '0;
    end else if (ref_tick) begin
      ref_tmr_reg <= '0;
    end else begin
      ref_tmr_reg <= ref_tmr_reg + REFT_W'(1);
    end
  end

  // backlog saturates; a tick and a completed refresh in the same cycle cancel out
  always_ff @(posedge mclk_i) begin
    if (rst_i || sr_done) begin
      pend_reg <= '0;
    end else if (ref_tick && !ref_done) begin
      pend_reg <= (pend_reg == PEND_MAX) ? pend_reg : pend_reg + PEND_W'(1);
    end else if (!ref_tick && ref_done && pend_reg != '0) begin
      pend_reg <= pend_reg - PEND_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down residency

  always_ff @(posedge mclk_i) begin
    if (rst_i || state_reg != ST_PD) begin
      pd_cnt_reg <= '0;
    end else begin
      pd_cnt_reg <= pd_cnt_reg + PD_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output mask ahead of a write that cuts a read

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_cnt_reg <= '0;
      dqm_reg      <= 1'b1;
    end else begin
      if (rd_wr_turn_i) begin
        mask_cnt_reg <= MASK_LEAD;
      end else if (mask_cnt_reg != '0) begin
        mask_cnt_reg <= mask_cnt_reg - 2'h1;
      end
      dqm_reg <= dqm_i || rd_wr_turn_i || (mask_cnt_reg > 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_reg <= '0;
    end else begin
      mode_reg.refreshing   <= (state_next == ST_PRE_WAIT) || (state_next == ST_REF_WAIT);
      mode_reg.self_refresh <= (state_next == ST_SR_HOLD) || (state_next == ST_SR_CLK) ||
                               (state_next == ST_SR_EXIT);
      mode_reg.power_down   <= (state_next == ST_PD);
      mode_reg.suspended    <= (state_reg == ST_IDLE) && suspend && !take;
    end
  end

  assign cmd_ready_o  = ready_reg;
  assign sd_cmd_o     = cmd_reg;
  assign sd_cke_o     = cke_reg;
  assign sd_dqm_o     = dqm_reg;
  assign sd_clk_run_o = clk_run_reg;
  assign mode_o       = mode_reg;

endmodule // srp_ctrl

`default_nettype wire

// file: design/srp_pkg.sv
package srp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing figures
  localparam int CLK_MHZ          = 25;
  localparam int CLK_PERIOD_NS    = 40;
  // plain defaults, set to the fitted part's figures
  localparam int ROW_PRECHARGE_TIME_NS  = 20;
  localparam int REFRESH_CYCLE_TIME_NS  = 66;
  localparam int ROW_ACTIVE_TIME_NS     = 44;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 75;
  localparam int CLK_STABLE_NS          = 200;
  localparam int REFRESH_PERIOD_MS      = 64;
  localparam int REFRESH_ROWS           = 4096;
  localparam int SR_EXIT_MIN_CLKS       = 2;

  // least times round up, longest times round down
  localparam int TRP_CYC  = (ROW_PRECHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ROW_ACTIVE_TIME_CYC = (ROW_ACTIVE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SELF_REFRESH_EXIT_TIME_RAW = (SELF_REFRESH_EXIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SELF_REFRESH_EXIT_TIME_CYC = (SELF_REFRESH_EXIT_TIME_RAW > SR_EXIT_MIN_CLKS) ? SELF_REFRESH_EXIT_TIME_RAW : SR_EXIT_MIN_CLKS;
  localparam int CLKST_CYC = (CLK_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_INT_CYC = (REFRESH_PERIOD_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
  localparam int PD_LIMIT_CYC = REFRESH_PERIOD_MS * 1000 * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int ADDR_W    = 12;
  localparam int BA_W      = 2;
  localparam int WAIT_W    = 8;
  localparam int REFT_W    = 10;
  localparam int PEND_W    = 4;
  localparam int PD_W      = 21;
  localparam logic [PEND_W-1:0] PEND_MAX = 4'h8;
  localparam logic [1:0] MASK_LEAD = 2'h2;
  localparam int A10_POS   = 10;
  localparam logic RST_CKE     = 1'b1;
  localparam logic RST_CLK_RUN = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // command pins
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } srp_cmd_t;

  localparam srp_cmd_t CMD_INHIBIT = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
  localparam srp_cmd_t CMD_NOP     = '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
  localparam srp_cmd_t CMD_PRE_ALL = '{1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 12'h400};
  localparam srp_cmd_t CMD_REFRESH = '{1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 12'h000};

  typedef struct packed {
    logic refreshing;
    logic self_refresh;
    logic power_down;
    logic suspended;
  } srp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE_WAIT, ST_REF_WAIT, ST_SR_HOLD, ST_SR_CLK, ST_SR_EXIT, ST_PD
  } srp_state_t;

endpackage : srp_pkg

// file: bench/srp_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module srp_ctrl_checker
  import srp_pkg::*;
#(
  parameter int PD_LIMIT = PD_LIMIT_CYC
) (
  input wire logic      mclk_i,
  input wire logic      rst_i,
  input wire logic      cmd_valid_i,
  input wire srp_cmd_t  cmd_i,
  input wire logic      dqm_i,
  input wire logic      rd_wr_turn_i,
  input wire logic      burst_active_i,
  input wire logic      suspend_req_i,
  input wire logic      self_ref_req_i,
  input wire logic      power_down_req_i,
  input wire logic      cmd_ready_o,
  input wire srp_cmd_t  sd_cmd_o,
  input wire logic      sd_cke_o,
  input wire logic      sd_dqm_o,
  input wire logic      sd_clk_run_o,
  input wire srp_mode_t mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire logic quiet = sd_cmd_o.cs_n || (sd_cmd_o.ras_n && sd_cmd_o.cas_n && sd_cmd_o.we_n);
  wire logic is_ref = !sd_cmd_o.cs_n && !sd_cmd_o.ras_n && !sd_cmd_o.cas_n && sd_cmd_o.we_n;
  wire logic pre_all = !sd_cmd_o.cs_n && !sd_cmd_o.ras_n && sd_cmd_o.cas_n
                       && !sd_cmd_o.we_n && sd_cmd_o.addr[A10_POS];
  int pd_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // self refresh hold is exempt: the part refreshes itself there
  always_ff @(posedge mclk_i) begin
    if (rst_i || sd_cke_o || !sd_clk_run_o) begin
      pd_cnt <= 0;
    end else begin
      pd_cnt <= pd_cnt + 1;
    end
  end
  sequence s_sr_exit;
    $rose(sd_clk_run_o) ##0 (!sd_cke_o)[*5] ##1 sd_cke_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_PRE_THEN_REF: assert property (is_ref |-> $past(pre_all))
    else $error("refresh without precharge-all before it");
  AST_REF_QUIET: assert property (is_ref && sd_cke_o |=> quiet [*2])
    else $error("command during refresh cycle time");
  AST_SR_CKE_LOW: assert property (!sd_clk_run_o |-> !sd_cke_o)
    else $error("clock enable high in self refresh");
  AST_SR_MIN_STAY: assert property ($fell(sd_clk_run_o) |-> (!sd_clk_run_o) [*2])
    else $error("self refresh too short");
  AST_CLK_BEFORE_CKE: assert property ($rose(sd_clk_run_o) |-> (!sd_cke_o) [*5])
    else $error("clock enable raised before clock stable");
  AST_SR_EXIT_NOP: assert property (s_sr_exit |-> quiet ##1 quiet)
    else $error("no two quiet cycles after self refresh exit");
  AST_PD_ENTRY_NOP: assert property ($fell(sd_cke_o) && !is_ref && !burst_active_i
      && !$past(burst_active_i) |-> quiet)
    else $error("power-down entered without quiet command");
  AST_PD_EXIT_NOP: assert property ($rose(sd_cke_o) |-> quiet)
    else $error("clock enable raised with a command");
  AST_PD_LIMIT: assert property (!sd_cke_o |-> pd_cnt <= PD_LIMIT + 1)
    else $error("power-down held too long");
  AST_MASK_LEAD: assert property (rd_wr_turn_i |=> sd_dqm_o [*2])
    else $error("mask not raised ahead of write");
endmodule // srp_ctrl_checker
bind srp_ctrl srp_ctrl_checker #(.PD_LIMIT(PD_LIMIT)) u_chk (.*);
`default_nettype wire

// file: bench/srp_sdram_model.sv
`timescale 1ns/100ps
`default_nettype none
module srp_sdram_model
  import srp_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire srp_cmd_t     cmd_i,
  input  wire logic         cke_i,
  input  wire logic         clk_run_i,
  output logic [ADDR_W-1:0] row_o,
  output logic              fault_o
);
  logic in_sr;
  logic frozen;
  logic row_open;
  logic wr_on;
  logic [BA_W-1:0] wr_bank;
  int   wr_beats;
  int   last_beat;
  int   apr_wait;
  // plain default for the write recovery time in cycles
  localparam int WR_RECOVERY_CYC = 1;
  int   rfc;
  int   sr_ticks;
  wire logic quiet = cmd_i.cs_n || (cmd_i.ras_n && cmd_i.cas_n && cmd_i.we_n);
  wire logic is_ref = !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
  wire logic is_wr = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
  // own timer, runs with the outside clock stopped
  always #(3 * CLK_PERIOD_NS) if (in_sr) sr_ticks++;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      {in_sr, frozen, row_open, fault_o} <= 4'h0;
      rfc <= 0;
      row_o <= '0;
      wr_on <= 1'b0;
      wr_bank <= '0;
      wr_beats <= 0;
      last_beat <= 0;
      apr_wait <= 0;
    end else if (in_sr) begin
      if (cke_i && !clk_run_i) fault_o <= 1'b1;
      if (cke_i) in_sr <= 1'b0; // other pins ignored
    end else if (frozen) begin
      frozen <= !cke_i;
    end else begin
      if (rfc > 0) rfc <= rfc - 1;
      if (!quiet && rfc > 0) fault_o <= 1'b1; // also covers exit wait
      if (is_ref) begin
        row_o <= row_o + 1'b1; // address pins unused
        if (row_open) fault_o <= 1'b1;
        rfc <= REFRESH_CYCLE_TIME_CYC;
        in_sr <= !cke_i;
      end else if (!cke_i) frozen <= 1'b1; // buffers off, no refresh
      if (!cmd_i.cs_n && !cmd_i.ras_n && cmd_i.cas_n) row_open <= cmd_i.we_n;
      if (wr_on) wr_beats <= wr_beats + 1;
      if (apr_wait == 1) row_open <= 1'b0;
      if (apr_wait > 0) apr_wait <= apr_wait - 1;
      if (is_wr) begin
        if (wr_on && cmd_i.ba != wr_bank) begin
          last_beat <= wr_beats; // beat before the cutting write
          apr_wait <= WR_RECOVERY_CYC;
        end
        wr_on <= cmd_i.addr[A10_POS];
        wr_bank <= cmd_i.ba;
        wr_beats <= 1;
      end
    end
  end
endmodule // srp_sdram_model
`default_nettype wire

// file: bench/srp_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module srp_ctrl_tb;
  import srp_pkg::*;
  localparam int PDL = 50;
  logic mclk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, dqm_i = 1'b0;
  logic rd_wr_turn_i = 1'b0, burst_active_i = 1'b0, suspend_req_i = 1'b0;
  logic self_ref_req_i = 1'b0, power_down_req_i = 1'b0;
  logic cmd_ready_o, sd_cke_o, sd_dqm_o, sd_clk_run_o, fault;
  srp_cmd_t sd_cmd_o, cmd_i = CMD_NOP;
  srp_mode_t mode_o;
  logic [ADDR_W-1:0] row;
  int mismatches = 0, checked = 0, n;
  always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  srp_ctrl #(.PD_LIMIT(PDL)) dut (.*);
  srp_sdram_model mem (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_i(sd_cmd_o), .cke_i(sd_cke_o),
    .clk_run_i(sd_clk_run_o), .row_o(row), .fault_o(fault));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_cke(input logic lvl, input int lim, output int c);
    for (c = 0; c < lim && sd_cke_o !== lvl; c++) step(1);
  endtask
  task automatic count_refs(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      step(1);
      if (sd_cmd_o === CMD_REFRESH) begin
        c++;
        chk(mode_o.refreshing, 1'b1);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // ready is judged while it stands, so the next edge is the take edge
  task automatic send(input srp_cmd_t c);
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    #1;
    for (int i = 0; i < 600 && cmd_ready_o !== 1'b1; i++) step(1);
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    #1 chk(sd_cmd_o, c);
  endtask
  task automatic t_cmd();
    srp_cmd_t act = '{1'b0, 1'b0, 1'b1, 1'b1, 2'h1, 12'h123};
    srp_cmd_t wr1 = '{1'b0, 1'b1, 1'b0, 1'b0, 2'h1, 12'h400};
    srp_cmd_t wr2 = '{1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 12'h000};
    send(act);
    send(wr1);
    send(wr2);
    step(3);
    // one idle cycle between the writes: two beats stored
    chk(mem.last_beat, 2);
    chk(mem.row_open, 1'b0);
  endtask
  task automatic t_mask();
    @(posedge mclk_i) rd_wr_turn_i <= 1'b1;
    @(posedge mclk_i) rd_wr_turn_i <= 1'b0;
    #1 chk(sd_dqm_o, 1'b1);
    step(1);
    chk(sd_dqm_o, 1'b1);
    step(1);
    chk(sd_dqm_o, 1'b0);
  endtask
  task automatic t_suspend();
    @(posedge mclk_i) suspend_req_i <= 1'b1;
    step(3);
    chk(sd_cke_o, 1'b1); // no burst, no suspend
    @(posedge mclk_i) burst_active_i <= 1'b1;
    wait_cke(1'b0, 4, n);
    chk(sd_cke_o, 1'b0);
    chk(mode_o.suspended, 1'b1);
    @(posedge mclk_i) suspend_req_i <= 1'b0;
    wait_cke(1'b1, 4, n);
    chk(sd_cke_o, 1'b1);
    @(posedge mclk_i) burst_active_i <= 1'b0;
  endtask
  task automatic t_refresh();
    step(10);
    count_refs(2 * REF_INT_CYC, n);
    chk(n, 2);
  endtask
  task automatic t_power_down();
    @(posedge mclk_i) power_down_req_i <= 1'b1;
    wait_cke(1'b0, 20, n);
    chk(mode_o.power_down, 1'b1);
    @(posedge mclk_i) power_down_req_i <= 1'b0;
    wait_cke(1'b1, 4, n);
    chk(sd_cke_o, 1'b1);
    @(posedge mclk_i) power_down_req_i <= 1'b1;
    wait_cke(1'b0, 20, n);
    wait_cke(1'b1, PDL + 20, n);
    chk(n <= PDL + 2, 1'b1);
    @(posedge mclk_i) power_down_req_i <= 1'b0;
    step(5);
  endtask
  task automatic t_self_ref();
    @(posedge mclk_i) self_ref_req_i <= 1'b1;
    wait_cke(1'b0, 20, n);
    step(30);
    chk({sd_cke_o, sd_clk_run_o, mode_o.self_refresh}, 3'h1);
    @(posedge mclk_i) self_ref_req_i <= 1'b0;
    wait_cke(1'b1, 30, n);
    chk(n >= CLKST_CYC, 1'b1);
    count_refs(REF_INT_CYC + 20, n);
    chk(n, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    chk(fault, 1'b0);
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    step(3);
    t_cmd();
    t_mask();
    t_suspend();
    t_refresh();
    t_power_down();
    t_self_ref();
    tally_and_finish();
  end
  initial begin // whole run is near 1350 cycles
    #(5000 * CLK_PERIOD_NS);
    mismatches++;
    tally_and_finish();
  end
endmodule // srp_ctrl_tb
`default_nettype wire
